// ### rtl/dram_map_pkg.sv
/*
  Constants for the motherboard DRAM address map: register ports, field
  positions, reset values, size table codes and T-state encodings.
  Assumes a 24-bit byte address and 8-bit configuration registers.
*/
package dram_map_pkg;

  // ----------------------------------------------------------------------
  // Register ports and field positions
  // ----------------------------------------------------------------------
  localparam logic [15:0] CFG_ONE_PORT     = 16'hFC81;
  localparam logic [15:0] CFG_TWO_PORT     = 16'hFC82;
  localparam logic [15:0] SHADOW_EN_PORT   = 16'hFC83;
  localparam logic [15:0] ROM_SHADOW_PORT  = 16'hFC84;

  localparam int          INTERLEAVE_BIT   = 7;
  localparam int          RELOCATE_BIT     = 6;
  localparam int          SIZE_LSB         = 3;
  localparam int          VARIANT_BIT      = 7;
  localparam int          VIDEO_PRIV_LSB   = 6;
  localparam int          SYSTEM_PRIV_LSB  = 2;
  localparam int          SYS_ROM_BIT      = 0;
  localparam int          VID_ROM_BIT      = 1;

  localparam logic [7:0]  CFG_RESET        = 8'h00;
  localparam logic [7:0]  REG_RESET        = 8'h00;

  // ----------------------------------------------------------------------
  // Address map constants, 24-bit byte addresses
  // ----------------------------------------------------------------------
  localparam logic [23:0] KB512            = 24'h080000;
  localparam logic [23:0] KB640            = 24'h0A0000;
  localparam logic [23:0] MB1              = 24'h100000;
  localparam logic [23:0] MB2              = 24'h200000;
  localparam logic [23:0] MB4              = 24'h400000;
  localparam logic [23:0] MB5              = 24'h500000;
  localparam logic [23:0] MB8              = 24'h800000;
  localparam logic [23:0] HOLE_SIZE        = 24'h060000;
  // Shadow windows: video BIOS C0000-C7FFF, system BIOS F0000-FFFFF.
  localparam logic [23:0] VID_BIOS_LO      = 24'h0C0000;
  localparam logic [23:0] VID_BIOS_HI      = 24'h0C8000;
  localparam logic [23:0] SYS_BIOS_LO      = 24'h0F0000;
  localparam logic [23:0] VID_RAM_LO       = 24'h0A0000;
  localparam logic [23:0] VID_RAM_HI       = 24'h0C0000;
  // The four 32 kB segment shadows end here; E0000-EFFFF has no shadow bit.
  localparam logic [23:0] SEG_ROM_HI       = 24'h0E0000;
  localparam int          SEG_LSB          = 15;

  // ----------------------------------------------------------------------
  // Size field codes and privilege codes
  // ----------------------------------------------------------------------
  localparam logic [2:0]  SZ_512K = 3'h0;
  localparam logic [2:0]  SZ_2M_A = 3'h1;
  localparam logic [2:0]  SZ_1M   = 3'h2;
  localparam logic [2:0]  SZ_4M   = 3'h3;
  localparam logic [2:0]  SZ_2M_B = 3'h4;
  localparam logic [2:0]  SZ_5M   = 3'h5;
  localparam logic [2:0]  SZ_8M   = 3'h6;
  localparam logic [2:0]  SZ_640K = 3'h7;

  localparam logic [1:0]  PRIV_OFF = 2'h0;
  localparam logic [1:0]  PRIV_RO  = 2'h1;
  localparam logic [1:0]  PRIV_WO  = 2'h2;
  localparam logic [1:0]  PRIV_RW  = 2'h3;

  typedef enum logic [3:0] {
    T_IDLE   = 4'h1,
    T_STATUS = 4'h2,
    T_CMD    = 4'h4,
    T_WAIT   = 4'h8
  } tstate_t;

endpackage

// ### rtl/region_decode.sv
/*
  Combinational address decoder: motherboard size range, hole relocation
  and shadow privilege. Assumes registered configuration inputs on the
  processor clock; results are sampled by the caller in the status state.
*/
`timescale 1ns/1ps
module region_decode (
  // Access
  input  wire logic [23:0] addr,
  input  wire logic        is_write,
  // Configuration
  input  wire logic [2:0]  size_code,
  input  wire logic        relocate,
  input  wire logic [5:0]  shadow_en,
  input  wire logic [7:0]  rom_shadow,
  // Results
  output logic             on_board,
  output logic             to_expansion,
  output logic             rom_decode,
  output logic [23:0]      dram_addr
);

  logic [23:0] top;
  logic        big;
  logic        in_hole;
  logic        in_remap;
  logic        shadowed;
  logic        vid_ram;
  logic [1:0]  priv;
  logic        priv_ok;

  always_comb begin
    case (size_code)
      dram_map_pkg::SZ_512K: top = dram_map_pkg::KB512;
      dram_map_pkg::SZ_2M_A: top = dram_map_pkg::MB2;
      dram_map_pkg::SZ_1M:   top = dram_map_pkg::MB1;
      dram_map_pkg::SZ_4M:   top = dram_map_pkg::MB4;
      dram_map_pkg::SZ_2M_B: top = dram_map_pkg::MB2;
      dram_map_pkg::SZ_5M:   top = dram_map_pkg::MB5;
      dram_map_pkg::SZ_8M:   top = dram_map_pkg::MB8;
      default:               top = dram_map_pkg::KB640;
    endcase
    big = (top >= dram_map_pkg::MB1);
    in_hole = (addr >= dram_map_pkg::KB640) && (addr < dram_map_pkg::MB1);
    // Types 1 and 8 are below 1 MB and never relocate.
    in_remap = relocate && big && (addr >= top)
               && (addr < top + dram_map_pkg::HOLE_SIZE);
    // Video RAM window is shadow enable bit 0, then four 32 kB ROM segments and the system BIOS.
    vid_ram = (addr >= dram_map_pkg::VID_RAM_LO) && (addr < dram_map_pkg::VID_RAM_HI);
    if (vid_ram) begin
      shadowed = shadow_en[0];
    end else if (addr >= dram_map_pkg::SYS_BIOS_LO) begin
      shadowed = shadow_en[5];
    end else if (addr >= dram_map_pkg::VID_RAM_HI && addr < dram_map_pkg::SEG_ROM_HI) begin
      shadowed = shadow_en[3'(addr[17:dram_map_pkg::SEG_LSB]) - 3'h7];
    end else begin
      // Beyond the segment shadows the index would reach bit 5 or leave the enable field.
      shadowed = 1'b0;
    end
    if (addr >= dram_map_pkg::SYS_BIOS_LO) begin
      priv = rom_shadow[dram_map_pkg::SYSTEM_PRIV_LSB +: 2];
    end else begin
      priv = rom_shadow[dram_map_pkg::VIDEO_PRIV_LSB +: 2];
    end
    priv_ok = is_write ? priv[1] : priv[0];
    rom_decode = 1'b0;
    on_board = 1'b0;
    dram_addr = addr;
    if (in_hole) begin
      // Shadow exists only with 1 MB or more configured.
      on_board = big && shadowed && (vid_ram || priv_ok);
      if (addr >= dram_map_pkg::VID_BIOS_LO && addr < dram_map_pkg::VID_BIOS_HI) begin
        rom_decode = !rom_shadow[dram_map_pkg::VID_ROM_BIT] && !on_board;
      end else if (addr >= dram_map_pkg::SYS_BIOS_LO) begin
        rom_decode = !rom_shadow[dram_map_pkg::SYS_ROM_BIT] && !on_board;
      end
    end else if (in_remap) begin
      on_board = 1'b1;
      dram_addr = addr - top + dram_map_pkg::KB640;
    end else begin
      on_board = (addr < top);
    end
    // Shadowed video RAM writes also go out on the expansion bus.
    to_expansion = !on_board || (vid_ram && is_write);
  end

endmodule

// ### rtl/dram_address_map.sv
/*
  Motherboard DRAM address map front end. Traces processor T-states,
  decodes the address in the status state, steers the data buffers and
  holds the four configuration registers on the IO port space.
  Assumes CLK is the processor clock and bus inputs are synchronous to it.
*/
// Operation
// - The whole controller runs on the processor clock.
// - Decode the 24-bit address in the status T-state.
// - Non-board accesses leave memory control outputs unchanged.
// - Board accesses produce RAS, CAS, write strobe and output enable.
// - Buffer direction is 1 on board memory writes.
// - Buffer direction is 0 on board memory reads.
// - Buffer enable asserted low on every board memory access.
// - Size field selects the board memory range.
// - Out-of-range accesses go to the expansion bus.
// - Shadow RAM only when at least 1 MB is configured.
// - Two privilege fields select off, read, write or read/write.
// - ROM enable bits set disable the ROM BIOS decode.
// - Shadow enable bits turn on matching shadow regions.
// - Enabled shadow runs as DRAM cycles, not ROM cycles.
// - Shadowed video writes go to DRAM and expansion bus.
// - Relocation bit remaps the hole to top of memory.
// - Remap window is 384 kB above top; types 1 and 8 none.
// - Conventional mode after reset; interleave bit selects page mode.
// - Interleave variant bit loaded from strap, fixed until reset.
`timescale 1ns/1ps
module dram_address_map (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RST,
  // Processor local bus
  input  wire logic [23:0] LOCAL_ADDRESS_BUS,
  input  wire logic        MEM_CYCLE,
  input  wire logic        STATUS_STATE,
  input  wire logic        CYCLE_END,
  input  wire logic        WRITE_CYCLE,
  // IO register port
  input  wire logic [15:0] IO_ADDR,
  input  wire logic        IO_WR,
  input  wire logic        IO_RD,
  input  wire logic [7:0]  IO_WDATA,
  output logic [7:0]       IO_RDATA,
  // Strap
  input  wire logic        VARIANT_STRAP,
  // Memory controls
  output logic             BUFFER_DIRECTION,
  output logic             BUFFER_OUTPUT_ENABLE_N,
  output logic             RAS_N,
  output logic             CAS_N,
  output logic             WE_N,
  output logic             EXPANSION_CYCLE,
  output logic             ROM_SELECT,
  output logic [23:0]      DRAM_ADDRESS,
  output logic             PAGE_MODE,
  output logic             ENHANCED_MODE
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    dram_map_pkg::tstate_t tst;
    logic [7:0]            cfg_one;
    logic [7:0]            cfg_two;
    logic [7:0]            shadow_en;
    logic [7:0]            rom_shadow;
    logic [1:0]            strap_sync;
    logic [7:0]            rdata;
    logic                  dir;
    logic                  oe_n;
    logic                  ras_n;
    logic                  cas_n;
    logic                  we_n;
    logic                  exp;
    logic                  rom;
    logic [23:0]           daddr;
  } state_t;

  state_t cur;
  state_t next_cur;

  logic        on_board;
  logic        to_expansion;
  logic        rom_decode;
  logic [23:0] dram_addr;

  region_decode decode (
    .addr         (LOCAL_ADDRESS_BUS),
    .is_write     (WRITE_CYCLE),
    .size_code    (cur.cfg_one[dram_map_pkg::SIZE_LSB +: 3]),
    .relocate     (cur.cfg_one[dram_map_pkg::RELOCATE_BIT]),
    .shadow_en    (cur.shadow_en[5:0]),
    .rom_shadow   (cur.rom_shadow),
    .on_board     (on_board),
    .to_expansion (to_expansion),
    .rom_decode   (rom_decode),
    .dram_addr    (dram_addr)
  );

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_cur = cur;
    // The strap pin is not on the processor clock, so it passes two stages.
    next_cur.strap_sync = {cur.strap_sync[0], VARIANT_STRAP};
    if (IO_WR) begin
      case (IO_ADDR)
        dram_map_pkg::CFG_ONE_PORT:    next_cur.cfg_one = IO_WDATA;
        dram_map_pkg::CFG_TWO_PORT:
          next_cur.cfg_two[6:0] = IO_WDATA[6:0];
        dram_map_pkg::SHADOW_EN_PORT:  next_cur.shadow_en = {2'h0, IO_WDATA[5:0]};
        dram_map_pkg::ROM_SHADOW_PORT: next_cur.rom_shadow = IO_WDATA;
        default:                       next_cur.cfg_one = cur.cfg_one;
      endcase
    end
    if (IO_RD) begin
      case (IO_ADDR)
        dram_map_pkg::CFG_ONE_PORT:    next_cur.rdata = cur.cfg_one;
        dram_map_pkg::CFG_TWO_PORT:    next_cur.rdata = cur.cfg_two;
        dram_map_pkg::SHADOW_EN_PORT:  next_cur.rdata = cur.shadow_en;
        dram_map_pkg::ROM_SHADOW_PORT: next_cur.rdata = cur.rom_shadow;
        default:                       next_cur.rdata = 8'h00;
      endcase
    end
    case (cur.tst)
      dram_map_pkg::T_IDLE: begin
        if (MEM_CYCLE && STATUS_STATE) begin
          next_cur.tst = dram_map_pkg::T_STATUS;
          // Decision taken once, in the status state.
          next_cur.exp = to_expansion;
          next_cur.rom = rom_decode;
          if (on_board) begin
            next_cur.daddr = dram_addr;
            next_cur.dir   = WRITE_CYCLE;
            next_cur.oe_n  = 1'b0;
            next_cur.we_n  = !WRITE_CYCLE;
            next_cur.ras_n = 1'b0;
          end
          // Otherwise the memory controls keep their levels.
        end
      end
      dram_map_pkg::T_STATUS: begin
        next_cur.tst = dram_map_pkg::T_CMD;
        if (!cur.oe_n) begin
          next_cur.cas_n = 1'b0;
        end
      end
      dram_map_pkg::T_CMD: begin
        next_cur.tst = dram_map_pkg::T_WAIT;
      end
      dram_map_pkg::T_WAIT: begin
        if (CYCLE_END) begin
          next_cur.tst   = dram_map_pkg::T_IDLE;
          next_cur.exp   = 1'b0;
          next_cur.rom   = 1'b0;
          if (!cur.oe_n) begin
            next_cur.oe_n  = 1'b1;
            next_cur.ras_n = 1'b1;
            next_cur.cas_n = 1'b1;
            next_cur.we_n  = 1'b1;
          end
        end
      end
      default: next_cur.tst = dram_map_pkg::T_IDLE;
    endcase
    // Synchronous reset. The strap keeps shifting, so the variant bit is
    // settled well before release and cannot be written afterwards.
    if (RST) begin
      next_cur            = '0;
      next_cur.strap_sync = {cur.strap_sync[0], VARIANT_STRAP};
      next_cur.tst        = dram_map_pkg::T_IDLE;
      next_cur.cfg_one    = dram_map_pkg::CFG_RESET;
      next_cur.cfg_two    = dram_map_pkg::CFG_RESET;
      next_cur.cfg_two[dram_map_pkg::VARIANT_BIT] = cur.strap_sync[1];
      next_cur.shadow_en  = dram_map_pkg::REG_RESET;
      next_cur.rom_shadow = dram_map_pkg::REG_RESET;
      next_cur.dir        = 1'b1;
      next_cur.oe_n       = 1'b1;
      next_cur.ras_n      = 1'b1;
      next_cur.cas_n      = 1'b1;
      next_cur.we_n       = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK) begin
    cur <= next_cur;
  end

  assign IO_RDATA               = cur.rdata;
  assign BUFFER_DIRECTION       = cur.dir;
  assign BUFFER_OUTPUT_ENABLE_N = cur.oe_n;
  assign RAS_N                  = cur.ras_n;
  assign CAS_N                  = cur.cas_n;
  assign WE_N                   = cur.we_n;
  assign EXPANSION_CYCLE        = cur.exp;
  assign ROM_SELECT             = cur.rom;
  assign DRAM_ADDRESS           = cur.daddr;
  assign PAGE_MODE              = cur.cfg_one[dram_map_pkg::INTERLEAVE_BIT];
  assign ENHANCED_MODE          = cur.cfg_two[dram_map_pkg::VARIANT_BIT];

endmodule

// ### verif/dram_map_checker.sv
/*
  Port checks for the DRAM address map front end.
  Assumes one clock, CLK, and a synchronous active-high RST.
*/
`timescale 1ns/1ps
module dram_map_checker (
  // Clock, reset and requests
  input wire logic        CLK,
  input wire logic        RST,
  input wire logic        MEM_CYCLE,
  input wire logic        STATUS_STATE,
  input wire logic        WRITE_CYCLE,
  input wire logic [15:0] IO_ADDR,
  input wire logic        IO_WR,
  input wire logic        IO_RD,
  input wire logic [7:0]  IO_WDATA,
  // Answers
  input wire logic [7:0]  IO_RDATA,
  input wire logic        BUFFER_DIRECTION,
  input wire logic        BUFFER_OUTPUT_ENABLE_N,
  input wire logic        RAS_N,
  input wire logic        CAS_N,
  input wire logic        WE_N,
  input wire logic        EXPANSION_CYCLE,
  input wire logic        PAGE_MODE,
  input wire logic        ENHANCED_MODE
);
  // ----
  // Memory cycle and register checks
  // ----
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  dir_follows_write_a: assert property ($fell(BUFFER_OUTPUT_ENABLE_N) |->
    BUFFER_DIRECTION == $past(WRITE_CYCLE)) else $error("direction wrong");
  buffer_with_row_a: assert property ($fell(RAS_N) |-> $fell(BUFFER_OUTPUT_ENABLE_N))
    else $error("buffer enable missing");
  col_after_row_a: assert property ($fell(RAS_N) |-> ##1 !CAS_N)
    else $error("column strobe late");
  decode_in_status_a: assert property ($fell(RAS_N) |-> $past(STATUS_STATE && MEM_CYCLE))
    else $error("strobe without status");
  write_strobe_a: assert property ($fell(RAS_N) |-> WE_N == !BUFFER_DIRECTION)
    else $error("write strobe wrong");
  row_stands_a: assert property ($fell(RAS_N) |-> !RAS_N [*3])
    else $error("row strobe short");
  offboard_hold_a: assert property ($rose(EXPANSION_CYCLE) && !$past(WRITE_CYCLE) |->
    RAS_N && BUFFER_OUTPUT_ENABLE_N && $stable(BUFFER_DIRECTION)) else $error("off-board moved");
  page_bit_a: assert property (IO_WR && IO_ADDR == dram_map_pkg::CFG_ONE_PORT |=>
    PAGE_MODE == $past(IO_WDATA[7])) else $error("page mode wrong");
  strap_fixed_a: assert property (!$past(RST, 2) |-> $stable(ENHANCED_MODE))
    else $error("variant bit changed");
  unmapped_zero_a: assert property (IO_RD && (IO_ADDR < 16'hFC81 || IO_ADDR > 16'hFC84) |=>
    IO_RDATA == 8'h00) else $error("unmapped read not zero");
endmodule

bind dram_address_map dram_map_checker u_chk (
  .CLK(CLK), .RST(RST), .MEM_CYCLE(MEM_CYCLE), .STATUS_STATE(STATUS_STATE),
  .WRITE_CYCLE(WRITE_CYCLE), .IO_ADDR(IO_ADDR), .IO_WR(IO_WR), .IO_RD(IO_RD),
  .IO_WDATA(IO_WDATA), .IO_RDATA(IO_RDATA), .BUFFER_DIRECTION(BUFFER_DIRECTION),
  .BUFFER_OUTPUT_ENABLE_N(BUFFER_OUTPUT_ENABLE_N), .RAS_N(RAS_N), .CAS_N(CAS_N),
  .WE_N(WE_N), .EXPANSION_CYCLE(EXPANSION_CYCLE), .PAGE_MODE(PAGE_MODE),
  .ENHANCED_MODE(ENHANCED_MODE)
);

// ### verif/cpu_bus_model.sv
/*
  Processor local bus model: one memory cycle in two calls.
  Assumes the caller samples the answers between start and finish_cycle.
*/
`timescale 1ns/1ps
module cpu_bus_model (
  // Clock and strobe feedback
  input  wire logic   clk,
  input  wire logic   ras_n,
  // Local bus
  output logic [23:0] addr,
  output logic        mem,
  output logic        sts,
  output logic        cend,
  output logic        wr
);
  initial begin
    addr = 24'h000000;
    mem = 1'b0;
    sts = 1'b0;
    cend = 1'b0;
    wr = 1'b0;
  end

  task automatic start(input logic [23:0] a, input logic w);
    @(negedge clk);
    addr = a;
    wr = w;
    mem = 1'b1;
    sts = 1'b1;
    @(negedge clk);
    sts = 1'b0;
  endtask

  // The end is held until the row strobe rises again, for at most 8 more cycles, so a
  // controller slower than that is cut short; the bound keeps a stuck one from hanging the run.
  task automatic finish_cycle();
    repeat (2) @(negedge clk);
    cend = 1'b1;
    @(negedge clk);
    for (int n = 0; n < 8 && !ras_n; n++) @(negedge clk);
    cend = 1'b0;
    mem = 1'b0;
    addr = ~addr;
    wr = ~wr;
    @(negedge clk);
  endtask
endmodule

// ### verif/tb_motherboard_dram_address_map.sv
/*
  Bench for the DRAM address map: register tasks and memory cycles.
  Assumes the bus model and the bound checker.
*/
`timescale 1ns/1ps
module tb_motherboard_dram_address_map;
  `define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fails++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
  logic        clk, rst, io_wr, io_rd, strap, mem, sts, cend, wr;
  logic        dir, oe_n, ras_n, cas_n, we_n, exp_cyc, rom_sel, page_mode, enhanced;
  logic        seen_exp, seen_rom;
  logic [15:0] io_addr;
  logic [7:0]  io_wdata, io_rdata, rd;
  logic [23:0] addr, dram_addr, seen_da;
  int          fails, total_checks;
  logic [23:0] tops [8] = '{dram_map_pkg::KB512, dram_map_pkg::MB2, dram_map_pkg::MB1,
    dram_map_pkg::MB4, dram_map_pkg::MB2, dram_map_pkg::MB5, dram_map_pkg::MB8,
    dram_map_pkg::KB640};

  dram_address_map u_dut (
    .CLK(clk), .RST(rst), .LOCAL_ADDRESS_BUS(addr), .MEM_CYCLE(mem), .STATUS_STATE(sts),
    .CYCLE_END(cend), .WRITE_CYCLE(wr), .IO_ADDR(io_addr), .IO_WR(io_wr), .IO_RD(io_rd),
    .IO_WDATA(io_wdata), .IO_RDATA(io_rdata), .VARIANT_STRAP(strap),
    .BUFFER_DIRECTION(dir), .BUFFER_OUTPUT_ENABLE_N(oe_n), .RAS_N(ras_n), .CAS_N(cas_n),
    .WE_N(we_n), .EXPANSION_CYCLE(exp_cyc), .ROM_SELECT(rom_sel), .DRAM_ADDRESS(dram_addr),
    .PAGE_MODE(page_mode), .ENHANCED_MODE(enhanced));
  cpu_bus_model u_cpu (.clk(clk), .ras_n(ras_n), .addr(addr), .mem(mem), .sts(sts),
    .cend(cend), .wr(wr));

  // ----
  // Access tasks
  // ----
  task automatic io_write(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge clk);
    io_wr = 1'b0;
  endtask

  task automatic io_read(input logic [15:0] a, output logic [7:0] d);
    @(negedge clk);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge clk);
    io_rd = 1'b0;
    d = io_rdata;
  endtask

  task automatic acc(input logic [23:0] a, input logic w, input logic brd);
    u_cpu.start(a, w);
    seen_exp = exp_cyc;
    seen_rom = rom_sel;
    seen_da = dram_addr;
    `CHK({ras_n, oe_n}, {!brd, !brd})
    if (brd) `CHK(dir, w)
    u_cpu.finish_cycle();
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    report_and_stop();
  end

  // ----
  // Tests
  // ----
  initial begin
    {rst, io_wr, io_rd, strap, fails, total_checks} = {4'h9, 64'h0};
    io_addr = 16'h0000;
    io_wdata = 8'h00;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    `CHK({dir, oe_n, ras_n, cas_n, we_n, page_mode, enhanced}, 7'h7D)
    for (int i = 0; i < 4; i++) begin
      io_read(dram_map_pkg::CFG_ONE_PORT + 16'(i), rd);
      `CHK(rd, (i == 1) ? 8'h80 : 8'h00)
    end
    io_write(dram_map_pkg::CFG_TWO_PORT, 8'h00);
    io_read(dram_map_pkg::CFG_TWO_PORT, rd);
    `CHK(rd, 8'h80)
    io_read(16'hFC85, rd);
    `CHK(rd, 8'h00)
    io_write(dram_map_pkg::CFG_ONE_PORT, 8'h80);
    `CHK(page_mode, 1'b1)
    for (int i = 0; i < 8; i++) begin
      io_write(dram_map_pkg::CFG_ONE_PORT, 8'(i << dram_map_pkg::SIZE_LSB));
      acc((tops[i] == dram_map_pkg::MB1) ? 24'h09FFFE : tops[i] - 24'h2, 1'(i), 1'b1);
      acc(tops[i], 1'b0, 1'b0);
      `CHK(seen_exp, 1'b1)
    end
    io_write(dram_map_pkg::CFG_ONE_PORT, 8'h48);
    acc(24'h200100, 1'b0, 1'b1);
    `CHK(seen_da, 24'h0A0100)
    acc(24'h25FFFE, 1'b1, 1'b1);
    acc(24'h260000, 1'b0, 1'b0);
    io_write(dram_map_pkg::CFG_ONE_PORT, 8'h10);
    acc(dram_map_pkg::SYS_BIOS_LO, 1'b0, 1'b0);
    `CHK(seen_rom, 1'b1)
    io_write(dram_map_pkg::SHADOW_EN_PORT, 8'h23);
    for (int p = 0; p < 4; p++) begin
      io_write(dram_map_pkg::ROM_SHADOW_PORT, 8'(p * 68) | 8'h03);
      acc(dram_map_pkg::SYS_BIOS_LO, 1'b0, 1'(p));
      acc(dram_map_pkg::SYS_BIOS_LO, 1'b1, 1'(p >> 1));
      acc(dram_map_pkg::VID_BIOS_LO, 1'b0, 1'(p));
    end
    `CHK(seen_rom, 1'b0)
    acc(dram_map_pkg::VID_RAM_LO, 1'b1, 1'b1);
    `CHK(seen_exp, 1'b1)
    acc(dram_map_pkg::VID_RAM_LO, 1'b0, 1'b1);
    `CHK(seen_exp, 1'b0)
    acc(24'h0E8000, 1'b0, 1'b0);
    `CHK(seen_exp, 1'b1)
    io_write(dram_map_pkg::CFG_ONE_PORT, 8'h00);
    acc(dram_map_pkg::SYS_BIOS_LO, 1'b0, 1'b0);
    // A second reset with the strap low: registers clear and the variant
    // bit follows the new strap level.
    strap = 1'b0;
    rst = 1'b1;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    `CHK({dir, oe_n, ras_n, page_mode, enhanced}, 5'h1C)
    io_read(dram_map_pkg::SHADOW_EN_PORT, rd);
    `CHK(rd, 8'h00)
    acc(dram_map_pkg::KB512 - 24'h2, 1'b0, 1'b1);
    report_and_stop();
  end
endmodule
